// [supply_monitor_pkg.sv]
// Shared constants and types for the supply monitor control block
package supply_monitor_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and responses
  // ----------------------------------------------------------------
  localparam int         ADDR_W      = 5;
  localparam int         DATA_W      = 32;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFFSET       = 5'h00;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_OFFSET = 5'h04;
  localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFFSET  = 5'h08;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFFSET = 5'h0C;
  localparam logic [ADDR_W-1:0] MODE_OFFSET       = 5'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLAG_BIT       = 0;
  localparam int IRQ_EN_BIT     = 1;
  localparam int STATUS_BIT     = 2;
  localparam int EV_W           = 3;
  localparam int EV_LV_CHANGE   = 0;
  localparam int EV_CORE_RESET  = 1;
  localparam int EV_POR_RELEASE = 2;
  localparam int MODE_FPM_BIT   = 0;
  localparam int MODE_RPM_BIT   = 1;
  localparam int MODE_POR_BIT   = 2;
  localparam int MODE_LVR_BIT   = 3;

  // ----------------------------------------------------------------
  // Comparator inputs and their values during reset
  // ----------------------------------------------------------------
  localparam int         CMP_W     = 6;
  localparam logic [5:0] CMP_RESET = 6'h2D;

  typedef struct packed {
    logic core_above_lvr_deassert;
    logic core_below_lvr_assert;
    logic core_below_por;
    logic input_above_deassert;
    logic input_below_assert;
    logic regulator_enable_input;
  } cmp_type;

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              lv_status;
    logic              low_voltage_change_flag;
    logic              low_voltage_irq_enable;
    logic              core_undervoltage_reset;
    logic              por;
    logic              full_performance_mode;
    logic              reduced_power_mode;
    logic              irq_out;
    logic [EV_W-1:0]   irq_status;
    logic [EV_W-1:0]   irq_enable;
    logic              aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic              w_held;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [DATA_W-1:0] rdata;
  } ctrl_state_type;

  localparam ctrl_state_type STATE_RESET = '{por: 1'b1, default: '0};

endpackage

// [pin_filter.sv]
// Three-stage synchroniser with agreement filter for asynchronous levels
`timescale 1ns/1ns
module pin_filter #(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] level_o
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } sync_state_type;

  sync_state_type st;
  sync_state_type next_st;

  // First stage feeds only the second; the filter looks at stages two and three
  always_comb begin
    next_st        = st;
    next_st.s1     = async_i;
    next_st.s2     = st.s1;
    next_st.s3     = st.s2;
    next_st.stable = (st.s2 & st.s3) | (st.stable & (st.s2 ^ st.s3));
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '{RESET_VALUE, RESET_VALUE, RESET_VALUE, RESET_VALUE};
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.stable;

endmodule

// [supply_monitor_ctrl.sv]
// Supply monitor control: detector flag, resets, modes and register slave
//
// Contract
// [RQ1] Set the change flag whenever the low-voltage status toggles, either way; the forced clear to 0 on leaving full performance sets no flag.
// [RQ2] Detector works only in full performance mode; idle otherwise.
// [RQ3] In full performance, status goes 1 below assert, 0 above deassert.
// [RQ4] Interrupt when flag and enable are both 1, only in full performance; enabled irq_status events also drive the output in any mode.
// [RQ5] Entering reduced power mode leaves the change flag untouched.
// [RQ6] Power-on reset high while core supply is low, low once above.
// [RQ7] Power-on reset monitoring stays active in every mode.
// [RQ8] Core reset asserts below assert level, negates above deassert level.
// [RQ9] Core undervoltage reset only effective in full performance mode.
// [RQ10] Power-on reset high holds the device in reset until it falls.
// [RQ11] Writing 1 clears the change flag; 0 has no effect.
// [RQ12] Status bit is read-only at control bit 2.
// [RQ13] Enable bit 1 blocks requests at 0, passes the flag at 1.
// [RQ14] Regulator enable low means shutdown; high allows the other modes.
// [RQ15] Comparator levels are synchronised before edge detection.
// [RQ16] Stop mode selects reduced power, else full performance, when enabled.
//
// The AXI4-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module supply_monitor_ctrl (
  // Clock and reset
  input  wire logic                                   clk_i,
  input  wire logic                                   rst_n_i,
  // Analog comparators and device state
  input  wire supply_monitor_pkg::cmp_type            cmp_i,
  input  wire logic                                   stop_mode_i,
  // Reset, interrupt and mode outputs
  output logic                                        power_on_reset_o,
  output logic                                        core_undervoltage_reset_o,
  output logic                                        low_voltage_interrupt_o,
  output logic                                        full_performance_mode_o,
  output logic                                        reduced_power_mode_o,
  // AXI4-Lite write
  input  wire logic [supply_monitor_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                                   s_axi_awvalid,
  output logic                                        s_axi_awready,
  input  wire logic [supply_monitor_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                             s_axi_wstrb,
  input  wire logic                                   s_axi_wvalid,
  output logic                                        s_axi_wready,
  output logic [1:0]                                  s_axi_bresp,
  output logic                                        s_axi_bvalid,
  input  wire logic                                   s_axi_bready,
  // AXI4-Lite read
  input  wire logic [supply_monitor_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                                   s_axi_arvalid,
  output logic                                        s_axi_arready,
  output logic [supply_monitor_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                                  s_axi_rresp,
  output logic                                        s_axi_rvalid,
  input  wire logic                                   s_axi_rready
);

  supply_monitor_pkg::ctrl_state_type         st;
  supply_monitor_pkg::ctrl_state_type         next_st;
  supply_monitor_pkg::cmp_type                sy;
  logic [supply_monitor_pkg::CMP_W-1:0]       sy_bits;
  logic                                       lv_change;
  logic                                       lv_flag_clr;
  logic [supply_monitor_pkg::EV_W-1:0]        ev_set;
  logic [supply_monitor_pkg::EV_W-1:0]        ev_clr;
  logic [supply_monitor_pkg::ADDR_W-1:0]      wr_addr;
  logic [supply_monitor_pkg::ADDR_W-1:0]      rd_addr;

  // ----------------------------------------------------------------
  // Comparator synchronisation
  // ----------------------------------------------------------------
  // Comparators switch with no relation to clk_i, so each level is filtered
  pin_filter #(
    .WIDTH       (supply_monitor_pkg::CMP_W),
    .RESET_VALUE (supply_monitor_pkg::CMP_RESET)
  ) u_filter (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .async_i (cmp_i),
    .level_o (sy_bits)
  ); // see [RQ15]

  assign sy      = supply_monitor_pkg::cmp_type'(sy_bits);
  assign wr_addr = {st.awaddr[supply_monitor_pkg::ADDR_W-1:2], 2'h0};
  assign rd_addr = {s_axi_araddr[supply_monitor_pkg::ADDR_W-1:2], 2'h0};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st     = st;
    lv_flag_clr = 1'b0;
    ev_clr      = '0;

    // Modes follow the enable pin and stop state
    next_st.full_performance_mode = sy.regulator_enable_input & ~stop_mode_i; // see [RQ16] see [RQ14]
    next_st.reduced_power_mode = sy.regulator_enable_input & stop_mode_i;  // see [RQ16]

    // Input supply detector with hysteresis, forced idle outside full performance
    if (st.full_performance_mode) begin
      if (sy.input_below_assert) begin
        next_st.lv_status = 1'b1; // see [RQ3]
      end else if (sy.input_above_deassert) begin
        next_st.lv_status = 1'b0; // see [RQ3]
      end
    end else begin
      next_st.lv_status = 1'b0; // see [RQ2]
    end
    lv_change = st.full_performance_mode & (next_st.lv_status != st.lv_status); // see [RQ1] see [RQ2]

    // Core undervoltage reset, only effective in full performance
    if (st.full_performance_mode) begin
      if (sy.core_below_lvr_assert) begin
        next_st.core_undervoltage_reset = 1'b1; // see [RQ8]
      end else if (sy.core_above_lvr_deassert) begin
        next_st.core_undervoltage_reset = 1'b0; // see [RQ8]
      end
    end else begin
      next_st.core_undervoltage_reset = 1'b0; // see [RQ9]
    end

    // Power-on reset ignores mode and control bits entirely
    next_st.por = sy.core_below_por; // see [RQ6] see [RQ7] see [RQ10]

    ev_set = '0;
    ev_set[supply_monitor_pkg::EV_LV_CHANGE]   = lv_change;
    ev_set[supply_monitor_pkg::EV_CORE_RESET]  = next_st.core_undervoltage_reset & ~st.core_undervoltage_reset;
    ev_set[supply_monitor_pkg::EV_POR_RELEASE] = st.por & ~next_st.por;

    // Write address and data are taken independently
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata  = s_axi_wdata;
      next_st.wstrb  = s_axi_wstrb;
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end

    if (st.aw_held && st.w_held) begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = supply_monitor_pkg::RESP_OKAY;
      case (wr_addr)
        supply_monitor_pkg::CTRL_OFFSET: begin
          // Status bit is not writable
          if (st.wstrb[0]) begin
            next_st.low_voltage_irq_enable = st.wdata[supply_monitor_pkg::IRQ_EN_BIT];
            lv_flag_clr = st.wdata[supply_monitor_pkg::FLAG_BIT]; // see [RQ11] see [RQ12]
          end
        end
        supply_monitor_pkg::IRQ_CLEAR_OFFSET: begin
          if (st.wstrb[0]) begin
            ev_clr = st.wdata[supply_monitor_pkg::EV_W-1:0];
          end
        end
        supply_monitor_pkg::IRQ_ENABLE_OFFSET: begin
          if (st.wstrb[0]) begin
            next_st.irq_enable = st.wdata[supply_monitor_pkg::EV_W-1:0];
          end
        end
        supply_monitor_pkg::IRQ_STATUS_OFFSET,
        supply_monitor_pkg::MODE_OFFSET: begin
          next_st.bresp = supply_monitor_pkg::RESP_OKAY;
        end
        default: begin
          next_st.bresp = supply_monitor_pkg::RESP_SLVERR;
        end
      endcase
    end

    // A new change beats a clear in the same cycle; mode changes never clear
    next_st.low_voltage_change_flag =
      (st.low_voltage_change_flag & ~lv_flag_clr) | lv_change; // see [RQ5] see [RQ11] see [RQ1]
    next_st.irq_status = (st.irq_status & ~ev_clr) | ev_set;
    next_st.irq_out = (next_st.low_voltage_change_flag & next_st.low_voltage_irq_enable
                       & next_st.full_performance_mode)
                      | (|(next_st.irq_status & next_st.irq_enable)); // see [RQ4] see [RQ13]

    // Read channel
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = '0;
      next_st.rresp  = supply_monitor_pkg::RESP_OKAY;
      case (rd_addr)
        supply_monitor_pkg::CTRL_OFFSET: begin
          next_st.rdata[supply_monitor_pkg::STATUS_BIT] = st.lv_status; // see [RQ12]
          next_st.rdata[supply_monitor_pkg::IRQ_EN_BIT] = st.low_voltage_irq_enable;
          next_st.rdata[supply_monitor_pkg::FLAG_BIT]   = st.low_voltage_change_flag;
        end
        supply_monitor_pkg::IRQ_STATUS_OFFSET: begin
          next_st.rdata[supply_monitor_pkg::EV_W-1:0] = st.irq_status;
        end
        supply_monitor_pkg::IRQ_CLEAR_OFFSET: begin
          next_st.rdata = '0;
        end
        supply_monitor_pkg::IRQ_ENABLE_OFFSET: begin
          next_st.rdata[supply_monitor_pkg::EV_W-1:0] = st.irq_enable;
        end
        supply_monitor_pkg::MODE_OFFSET: begin
          next_st.rdata[supply_monitor_pkg::MODE_FPM_BIT] = st.full_performance_mode;
          next_st.rdata[supply_monitor_pkg::MODE_RPM_BIT] = st.reduced_power_mode;
          next_st.rdata[supply_monitor_pkg::MODE_POR_BIT] = st.por;
          next_st.rdata[supply_monitor_pkg::MODE_LVR_BIT] = st.core_undervoltage_reset;
        end
        default: begin
          next_st.rresp = supply_monitor_pkg::RESP_SLVERR;
        end
      endcase
    end

    // One write and one read in flight; ready drops while an answer waits
    next_st.awready = ~next_st.aw_held & ~next_st.bvalid;
    next_st.wready  = ~next_st.w_held & ~next_st.bvalid;
    next_st.arready = ~next_st.rvalid;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= supply_monitor_pkg::STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign power_on_reset_o          = st.por;
  assign core_undervoltage_reset_o = st.core_undervoltage_reset;
  assign low_voltage_interrupt_o   = st.irq_out;
  assign full_performance_mode_o   = st.full_performance_mode;
  assign reduced_power_mode_o      = st.reduced_power_mode;
  assign s_axi_awready             = st.awready;
  assign s_axi_wready              = st.wready;
  assign s_axi_bvalid              = st.bvalid;
  assign s_axi_bresp               = st.bresp;
  assign s_axi_arready             = st.arready;
  assign s_axi_rvalid              = st.rvalid;
  assign s_axi_rdata               = st.rdata;
  assign s_axi_rresp               = st.rresp;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_write_paired;
    st.aw_held && st.w_held;
  endsequence

  sequence s_write_answered;
    st.bvalid && !st.aw_held && !st.w_held;
  endsequence

  a_flag_on_change: assert property ( // see [RQ1]
    st.full_performance_mode && sy.input_below_assert && !st.lv_status
    |=> st.lv_status && st.low_voltage_change_flag)
    else $error("change flag not set on status toggle");

  a_detector_idle: assert property ( // see [RQ2]
    !st.full_performance_mode |=> !st.lv_status
    && ($stable(st.low_voltage_change_flag) || $fell(st.low_voltage_change_flag)))
    else $error("detector active outside full performance");

  a_status_clears: assert property ( // see [RQ3]
    st.full_performance_mode && !sy.input_below_assert && sy.input_above_deassert |=> !st.lv_status)
    else $error("status not cleared above deassert level");

  a_irq_raised: assert property ( // see [RQ4]
    st.low_voltage_change_flag && next_st.low_voltage_irq_enable && st.full_performance_mode && next_st.full_performance_mode
    && !lv_flag_clr |=> low_voltage_interrupt_o)
    else $error("interrupt missing with flag and enable set");

  a_flag_kept: assert property ( // see [RQ5]
    st.low_voltage_change_flag && !lv_flag_clr |=> st.low_voltage_change_flag)
    else $error("change flag lost without software clear");

  a_por_tracks: assert property ( // see [RQ7]
    sy.core_below_por |=> power_on_reset_o)
    else $error("power-on reset not high with core supply low");

  a_por_release: assert property ( // see [RQ6]
    !sy.core_below_por |=> !power_on_reset_o)
    else $error("power-on reset not released with core supply up");

  a_lvr_fpm_only: assert property ( // see [RQ9]
    !st.full_performance_mode |=> !core_undervoltage_reset_o)
    else $error("core reset asserted outside full performance");

  a_lvr_asserts: assert property ( // see [RQ8]
    st.full_performance_mode && sy.core_below_lvr_assert |=> core_undervoltage_reset_o)
    else $error("core reset not asserted below level");

  a_flag_clear: assert property ( // see [RQ11]
    lv_flag_clr && !lv_change |=> !st.low_voltage_change_flag)
    else $error("write of one did not clear the change flag");

  a_write_answer: assert property (
    s_write_paired |=> s_write_answered)
    else $error("paired write not answered next cycle");

endmodule

// [supply_model.sv]
// Behavioural model of the two supplies and their analog comparators
`timescale 1ns/1ns
module supply_model #(
  parameter int INPUT_LOW_ASSERT_LEVEL   = 4000,
  parameter int INPUT_LOW_DEASSERT_LEVEL = 4100,
  parameter int POWER_UP_DEASSERT_LEVEL  = 1400,
  parameter int CORE_LOW_ASSERT_LEVEL    = 2300,
  parameter int CORE_LOW_DEASSERT_LEVEL  = 2400
) (
  // Supply levels in millivolts and regulator enable pin
  input  wire logic [15:0]            input_mv_i,
  input  wire logic [15:0]            core_mv_i,
  input  wire logic                   regulator_enable_input_i,
  // Comparator levels
  output supply_monitor_pkg::cmp_type cmp_o
);
  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  // Plain threshold comparators; the hysteresis is the monitor's job
  always_comb begin
    cmp_o.input_below_assert      = int'(input_mv_i) < INPUT_LOW_ASSERT_LEVEL;
    cmp_o.input_above_deassert    = int'(input_mv_i) > INPUT_LOW_DEASSERT_LEVEL;
    cmp_o.core_below_por          = int'(core_mv_i) < POWER_UP_DEASSERT_LEVEL;
    cmp_o.core_below_lvr_assert   = int'(core_mv_i) < CORE_LOW_ASSERT_LEVEL;
    cmp_o.core_above_lvr_deassert = int'(core_mv_i) > CORE_LOW_DEASSERT_LEVEL;
    cmp_o.regulator_enable_input  = regulator_enable_input_i;
  end
endmodule

// [tb.sv]
// Self-checking testbench for the supply monitor control block
`timescale 1ns/1ns
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef logic [supply_monitor_pkg::ADDR_W-1:0] addr_type;
  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } rd_note_type;
  localparam addr_type CTRL_A = supply_monitor_pkg::CTRL_OFFSET;
  localparam addr_type STAT_A = supply_monitor_pkg::IRQ_STATUS_OFFSET;
  localparam addr_type CLR_A  = supply_monitor_pkg::IRQ_CLEAR_OFFSET;
  localparam addr_type EN_A   = supply_monitor_pkg::IRQ_ENABLE_OFFSET;
  localparam addr_type MODE_A = supply_monitor_pkg::MODE_OFFSET;
  localparam logic [1:0] OK   = supply_monitor_pkg::RESP_OKAY;
  localparam logic [1:0] ERR  = supply_monitor_pkg::RESP_SLVERR;
  logic                        clk_i, rst_n_i, stop_mode_i, regen;
  logic [15:0]                 input_mv, core_mv;
  supply_monitor_pkg::cmp_type cmp;
  logic                        por_o, lvr_o, irq_o, fpm_o, rpm_o;
  addr_type                    s_axi_awaddr, s_axi_araddr;
  logic [31:0]                 s_axi_wdata, s_axi_rdata, d;
  logic [3:0]                  s_axi_wstrb;
  logic [1:0]                  s_axi_bresp, s_axi_rresp;
  logic                        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                        s_axi_rvalid, s_axi_rready;
  int                          n_mismatch, n_tests, seed;
  rd_note_type                 rq[$];
  rd_note_type                 note;
  logic [1:0]                  wq[$];

  supply_model model (.input_mv_i(input_mv), .core_mv_i(core_mv),
    .regulator_enable_input_i(regen), .cmp_o(cmp));
  supply_monitor_ctrl DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmp_i(cmp),
    .stop_mode_i(stop_mode_i), .power_on_reset_o(por_o), .core_undervoltage_reset_o(lvr_o),
    .low_voltage_interrupt_o(irq_o), .full_performance_mode_o(fpm_o),
    .reduced_power_mode_o(rpm_o), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  always #50 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic pin(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask
  task automatic end_of_test;
    $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic settle;
    repeat (8) @(posedge clk_i);
  endtask

  // Responses are judged here, in the order the bus tasks noted them
  always @(posedge clk_i) begin
    if (s_axi_bvalid && s_axi_bready) begin
      check({30'h0, s_axi_bresp}, {30'h0, wq.pop_front()});
    end
    if (s_axi_rvalid && s_axi_rready) begin
      note = rq.pop_front();
      check({30'h0, s_axi_rresp}, {30'h0, note.resp});
      if (note.resp === OK) begin
        check(s_axi_rdata, note.data);
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus master
  // ----------------------------------------------------------------
  task automatic wr(input addr_type a, input logic [31:0] v, input logic [3:0] s,
                    input logic [1:0] r);
    logic aw, w, done;
    wq.push_back(r);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    done = 1'b0;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge clk_i);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
      end
    end
    if (!done) begin
      n_mismatch++;
      end_of_test();
    end
  endtask
  task automatic rd(input addr_type a, input logic [31:0] v, input logic [1:0] r);
    logic ar, done;
    rq.push_back('{v, r});
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ar = 1'b1;
    done = 1'b0;
    for (int i = 0; i < 50 && !done; i++) begin
      @(posedge clk_i);
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        done = 1'b1;
        s_axi_rready <= 1'b0;
      end
    end
    if (!done) begin
      n_mismatch++;
      end_of_test();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    rst_n_i = 1'b0;
    stop_mode_i = 1'b0;
    regen = 1'b1;
    input_mv = 16'd5000;
    core_mv = 16'd0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = '0;
    n_mismatch = 0;
    n_tests = 0;
    seed = 67;
    repeat (2) @(posedge clk_i);
    pin(por_o, 1'b1);
    rst_n_i <= 1'b1;
    settle();
    pin(por_o, 1'b1);
    pin(lvr_o, 1'b1);
    pin(fpm_o, 1'b1);
    core_mv <= 16'd2500;
    settle();
    pin(por_o, 1'b0);
    pin(lvr_o, 1'b0);
    rd(CTRL_A, 32'h0, OK);
    rd(MODE_A, 32'h1, OK);
    wr(CTRL_A, 32'h2, 4'hF, OK);
    rd(CTRL_A, 32'h2, OK);
    input_mv <= 16'd3900;
    repeat (2) @(posedge clk_i);
    pin(irq_o, 1'b0);
    settle();
    pin(irq_o, 1'b1);
    rd(CTRL_A, 32'h7, OK);
    input_mv <= 16'd4050;
    settle();
    rd(CTRL_A, 32'h7, OK);
    input_mv <= 16'd5000;
    settle();
    rd(CTRL_A, 32'h3, OK);
    wr(CTRL_A, 32'h6, 4'hF, OK);
    rd(CTRL_A, 32'h3, OK);
    wr(CTRL_A, 32'h3, 4'hF, OK);
    rd(CTRL_A, 32'h2, OK);
    pin(irq_o, 1'b0);
    wr(CTRL_A, 32'h0, 4'hF, OK);
    input_mv <= 16'd3900;
    settle();
    rd(CTRL_A, 32'h5, OK);
    pin(irq_o, 1'b0);
    wr(CTRL_A, 32'h2, 4'hF, OK);
    pin(irq_o, 1'b1);
    stop_mode_i <= 1'b1;
    settle();
    pin(irq_o, 1'b0);
    rd(MODE_A, 32'h2, OK);
    rd(CTRL_A, 32'h3, OK);
    wr(CTRL_A, 32'h3, 4'hF, OK);
    input_mv <= 16'd5000;
    settle();
    input_mv <= 16'd3900;
    settle();
    rd(CTRL_A, 32'h2, OK);
    core_mv <= 16'd2000;
    settle();
    pin(lvr_o, 1'b0);
    core_mv <= 16'd1000;
    settle();
    pin(por_o, 1'b1);
    core_mv <= 16'd2500;
    stop_mode_i <= 1'b0;
    settle();
    rd(CTRL_A, 32'h7, OK);
    wr(CTRL_A, 32'h1, 4'hF, OK);
    core_mv <= 16'd2000;
    settle();
    pin(lvr_o, 1'b1);
    core_mv <= 16'd2350;
    settle();
    pin(lvr_o, 1'b1);
    core_mv <= 16'd2500;
    settle();
    pin(lvr_o, 1'b0);
    regen <= 1'b0;
    settle();
    rd(MODE_A, 32'h0, OK);
    core_mv <= 16'd1000;
    settle();
    rd(MODE_A, 32'h4, OK);
    core_mv <= 16'd2500;
    regen <= 1'b1;
    settle();
    // Event register, its enable and its clear
    rd(STAT_A, 32'h7, OK);
    wr(EN_A, 32'h4, 4'hF, OK);
    pin(irq_o, 1'b1);
    wr(CLR_A, 32'h4, 4'hF, OK);
    pin(irq_o, 1'b0);
    rd(STAT_A, 32'h3, OK);
    rd(CLR_A, 32'h0, OK);
    wr(STAT_A, 32'h0, 4'hF, OK);
    wr(CLR_A, 32'h3, 4'hF, OK);
    rd(STAT_A, 32'h0, OK);
    // A write with no byte lane enabled leaves the enable word as it was
    wr(EN_A, 32'h7, 4'h0, OK);
    rd(EN_A, 32'h4, OK);
    wr(5'h14, 32'h1, 4'hF, ERR);
    rd(5'h14, 32'h0, ERR);
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      wr(EN_A, d, 4'hF, OK);
      rd(EN_A, {29'h0, d[2:0]}, OK);
    end
    repeat (2) @(posedge clk_i);
    check(rq.size() + wq.size(), 32'h0);
    end_of_test();
  end
endmodule
